// ---- verilog/dbm_pkg.sv ----
// holds constants and carrier types for the data memory bank mapper
// assumes a single 50 MHz core clock shared with the instruction decoder
//
// What this block does
// - access bit clear: access map, ignore bank pointer
// - access bit set: bank pointer plus opcode address
// - access offsets 00h-5Fh go to bank 0
// - access offsets 60h-FFh go to bank 15
// - access bank operation completes in one cycle
// - full address move uses its 12-bit addresses
// - extended isa changes access map, out of scope
// - general purpose ram never cleared by reset
// - general purpose ram starts at address 000h
// - special function registers occupy F60h to FFFh
// - unimplemented special function registers read zero
// - bank pointer upper four bits read zero
// - unimplemented banks: writes dropped, reads zero
// - bank pointer gives upper nibble, opcode lower byte
`default_nettype none

package dbm_pkg;
   // ***************************************************
   // address map
   // ***************************************************
   localparam int DBM_ADDR_W = 12;                       // data address width
   localparam logic [7:0] DBM_ACCESS_SPLIT = 8'h60;      // first upper access offset
   localparam logic [3:0] DBM_LOW_BANK = 4'h0;           // lower access window bank
   localparam logic [3:0] DBM_HIGH_BANK = 4'hF;          // upper access window bank
   localparam logic [11:0] DBM_GPR_BASE = 12'h000;       // general purpose ram base
   localparam logic [11:0] DBM_SFR_BASE = 12'hF60;       // first special function register
   localparam logic [11:0] DBM_SFR_TOP = 12'hFFF;        // last special function register
   localparam logic [11:0] DBM_BANK_PTR_ADDR = 12'hFE0;  // bank pointer address
   localparam logic [7:0] DBM_BANK_PTR_RST = 8'h00;      // bank pointer reset value
   localparam logic [3:0] DBM_BANK_PTR_MASK = 4'hF;      // implemented bank pointer bits
   localparam int DBM_GPR_BANKS = 2;                     // implemented ram banks

   // ***************************************************
   // carriers
   // ***************************************************
   typedef enum logic [1:0] {DBM_OP_NONE, DBM_OP_BANKED, DBM_OP_FULL} dbm_op_t;

   typedef struct packed {
      dbm_op_t op;        // kind of access
      logic access_sel;   // 1: banked, 0: access map
      logic [7:0] file;   // opcode file address
      logic [11:0] full;  // full address for full address move
      logic wr;           // write request
      logic [7:0] wdata;  // write data
   } dbm_req_t;

   typedef struct packed {
      logic valid;         // one-cycle answer strobe
      logic [11:0] addr;   // resolved data address
      logic [7:0] rdata;   // read data
      logic implemented;   // location exists
   } dbm_rsp_t;
endpackage

`default_nettype wire

// ---- verilog/dbm_ram.sv ----
// holds the general purpose ram array with a registered read port
// assumes clock only; contents carry no reset on purpose
`default_nettype none

module dbm_ram #(
   parameter int DEPTH = 512,
   parameter int AW = 9
) (
   // clock
   input wire logic clk,
   // access
   input wire logic we,
   input wire logic [AW-1:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   // ***************************************************
   // storage
   // ***************************************************
   logic [7:0] mem [DEPTH];  // no reset: contents survive every reset
   logic [7:0] rdata_q;      // registered read data

   // write and registered read, no reset
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata_q <= mem[addr];
   end
   assign rdata = rdata_q;
endmodule // dbm_ram

`default_nettype wire

// ---- verilog/dbm_mapper.sv ----
// holds the data memory bank mapper: address forming, bank pointer, ram and unmapped reads
// assumes a decoder on clk issuing at most one request per cycle; answers one cycle later
`default_nettype none

module dbm_mapper #(
   parameter int GPR_BANKS = dbm_pkg::DBM_GPR_BANKS
) (
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // configuration
   input wire logic extended_isa_enable,
   // decoder request
   input wire dbm_pkg::dbm_req_t req,
   // answer
   output dbm_pkg::dbm_rsp_t rsp,
   output logic [7:0] bank_pointer_o
);
   // ***************************************************
   // reset release
   // ***************************************************
   logic rst_s1_q, rst_s2_q;  // synchroniser stages
   logic rst_s1_d, rst_s2_d;  // next stage values
   logic rst_n;               // released reset

   // a one walks in behind the reset; only the second stage feeds logic
   always_comb begin
      rst_s1_d = 1'b1;
      rst_s2_d = rst_s1_q;
   end

   // two flops form the released reset rst_n; the bank pointer, answer and shadow flops
   // still clear on arst_n itself, so they see its raw release edge
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= rst_s1_d;
         rst_s2_q <= rst_s2_d;
      end
   end
   assign rst_n = rst_s2_q;

   // ***************************************************
   // address forming
   // ***************************************************
   localparam int RAM_DEPTH = GPR_BANKS * 256;
   localparam int RAM_AW = $clog2(RAM_DEPTH);

   logic [3:0] bank_q, bank_d;     // bank pointer, four bits implemented
   logic [11:0] addr_c;            // resolved address
   logic is_sfr, is_gpr, is_bptr;  // region decode
   logic active;                   // request present

   // combinational address resolution
   always_comb begin
      active = (req.op != dbm_pkg::DBM_OP_NONE);
      addr_c = dbm_pkg::DBM_GPR_BASE;
      case (req.op)
         dbm_pkg::DBM_OP_FULL: begin
            addr_c = req.full;
         end
         dbm_pkg::DBM_OP_BANKED: begin
            if (req.access_sel) begin
               addr_c = {bank_q, req.file};
            end else if (req.file < dbm_pkg::DBM_ACCESS_SPLIT) begin
               // extended isa remap not modelled, default map kept
               addr_c = {dbm_pkg::DBM_LOW_BANK, req.file};
            end else begin
               addr_c = {dbm_pkg::DBM_HIGH_BANK, req.file};
            end
         end
         default: begin
            addr_c = dbm_pkg::DBM_GPR_BASE;
         end
      endcase
      // ram from 000h upward, registers at the top
      is_gpr = (addr_c < 12'(RAM_DEPTH));
      is_sfr = (addr_c >= dbm_pkg::DBM_SFR_BASE);
      is_bptr = (addr_c == dbm_pkg::DBM_BANK_PTR_ADDR);
   end

   // ***************************************************
   // bank pointer
   // ***************************************************
   // only the low nibble stores; upper write bits dropped
   always_comb begin
      bank_d = bank_q;
      if (active && req.wr && is_bptr) begin
         bank_d = req.wdata[3:0] & dbm_pkg::DBM_BANK_PTR_MASK;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         bank_q <= dbm_pkg::DBM_BANK_PTR_RST[3:0];
      end else if (!rst_n) begin
         bank_q <= dbm_pkg::DBM_BANK_PTR_RST[3:0];
      end else begin
         bank_q <= bank_d;
      end
   end

   // ***************************************************
   // ram
   // ***************************************************
   logic ram_we;            // write into implemented ram only
   logic [7:0] ram_rdata;   // registered ram data

   // writes outside the ram are dropped
   assign ram_we = active && req.wr && is_gpr && rst_n;

   dbm_ram #(
      .DEPTH(RAM_DEPTH),
      .AW(RAM_AW)
   ) u_ram (
      .clk(clk),
      .we(ram_we),
      .addr(addr_c[RAM_AW-1:0]),
      .wdata(req.wdata),
      .rdata(ram_rdata)
   );

   // ***************************************************
   // answer
   // ***************************************************
   logic valid_q, valid_d;            // answer strobe
   logic [11:0] addr_q, addr_d;       // answered address
   logic gpr_q, gpr_d;                // answer comes from ram
   logic bptr_q, bptr_d;              // answer is bank pointer
   logic impl_q, impl_d;              // location implemented

   // capture the request kind; every access made once rst_n is high answers next cycle
   always_comb begin
      valid_d = active && rst_n;
      addr_d = addr_c;
      gpr_d = is_gpr;
      bptr_d = is_bptr;
      impl_d = is_gpr || is_bptr;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         valid_q <= 1'b0;
         addr_q <= 12'h000;
         gpr_q <= 1'b0;
         bptr_q <= 1'b0;
         impl_q <= 1'b0;
      end else begin
         valid_q <= valid_d;
         addr_q <= addr_d;
         gpr_q <= gpr_d;
         bptr_q <= bptr_d;
         impl_q <= impl_d;
      end
   end

   // read mux: unimplemented banks and registers give zero
   always_comb begin
      rsp.valid = valid_q;
      rsp.addr = addr_q;
      rsp.implemented = impl_q;
      if (gpr_q) begin
         rsp.rdata = ram_rdata;
      end else if (bptr_q) begin
         rsp.rdata = {4'h0, bank_q};
      end else begin
         rsp.rdata = 8'h00;
      end
   end
   assign bank_pointer_o = {4'h0, bank_q};

   // ***************************************************
   // checks
   // ***************************************************
   logic unused_cfg;
   assign unused_cfg = extended_isa_enable;

   // ***************************************************
   // check helpers
   // ***************************************************
   // shadow of the last ram write, so a later read of that byte can be checked;
   // it forgets on reset although the ram does not, which only costs coverage
   logic shadow_vld_q, shadow_vld_d;           // shadow holds a real write
   logic [11:0] shadow_addr_q, shadow_addr_d;  // address of the last ram write
   logic [7:0] shadow_data_q, shadow_data_d;   // data of the last ram write

   // follow every taken write whose address lies inside the ram
   always_comb begin
      shadow_vld_d = shadow_vld_q;
      shadow_addr_d = shadow_addr_q;
      shadow_data_d = shadow_data_q;
      if (active && req.wr && rst_n && addr_c < 12'(RAM_DEPTH)) begin
         shadow_vld_d = 1'b1;
         shadow_addr_d = addr_c;
         shadow_data_d = req.wdata;
      end
   end

   // shadow registers, cleared by reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shadow_vld_q <= 1'b0;
         shadow_addr_q <= 12'h000;
         shadow_data_q <= 8'h00;
      end else begin
         shadow_vld_q <= shadow_vld_d;
         shadow_addr_q <= shadow_addr_d;
         shadow_data_q <= shadow_data_d;
      end
   end

   // ***************************************************
   // assertions
   // ***************************************************

   // lower access window lands in bank 0
   access_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.op == dbm_pkg::DBM_OP_BANKED && !req.access_sel && req.file < 8'h60)
      |=> rsp.valid && rsp.addr == {4'h0, $past(req.file)})
      else $error("low access window misplaced");

   // upper access window lands in bank 15
   access_high_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.op == dbm_pkg::DBM_OP_BANKED && !req.access_sel && req.file >= 8'h60)
      |=> rsp.addr == {4'hF, $past(req.file)})
      else $error("high access window misplaced");

   // banked form takes the bank pointer of the request cycle
   banked_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.op == dbm_pkg::DBM_OP_BANKED && req.access_sel)
      |=> rsp.addr == {$past(bank_q), $past(req.file)})
      else $error("banked address wrong");

   // access form never looks at the bank pointer
   access_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.op == dbm_pkg::DBM_OP_BANKED && !req.access_sel)
      |=> rsp.addr[11:8] == ($past(req.file) < 8'h60 ? 4'h0 : 4'hF))
      else $error("access map used bank pointer");

   // full address move bypasses both maps
   full_move_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.op == dbm_pkg::DBM_OP_FULL) |=> rsp.addr == $past(req.full))
      else $error("full address not used");

   // every request answers in the next cycle
   one_cycle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.op != dbm_pkg::DBM_OP_NONE) |=> rsp.valid)
      else $error("answer not in one cycle");

   // no answer without a request
   valid_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.op == dbm_pkg::DBM_OP_NONE) |=> !rsp.valid)
      else $error("answer without request");

   // nothing answers while the released reset is still low
   reset_quiet_a: assert property (@(posedge clk)
      !rst_n |=> !rsp.valid)
      else $error("answer during reset");

   // unimplemented locations read as zero
   unimpl_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
      (rsp.valid && !rsp.implemented) |-> rsp.rdata == 8'h00)
      else $error("unimplemented read not zero");

   // bank pointer reads back with its upper nibble clear
   bptr_upper_a: assert property (@(posedge clk) disable iff (!rst_n)
      (rsp.valid && rsp.addr == dbm_pkg::DBM_BANK_PTR_ADDR) |-> rsp.rdata[7:4] == 4'h0)
      else $error("bank pointer upper bits set");

   // a write to the bank pointer keeps only its low nibble
   bank_write_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.op != dbm_pkg::DBM_OP_NONE && req.wr && is_bptr)
      |=> bank_pointer_o[3:0] == $past(req.wdata[3:0]))
      else $error("bank pointer not written");

   // no access elsewhere moves the bank pointer
   bank_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.op != dbm_pkg::DBM_OP_NONE && addr_c != dbm_pkg::DBM_BANK_PTR_ADDR)
      |=> $stable(bank_pointer_o))
      else $error("bank pointer moved without a write");

   // ram starts at 000h: every address below its depth is implemented
   gpr_region_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.op != dbm_pkg::DBM_OP_NONE && addr_c < 12'(RAM_DEPTH)) |=> rsp.implemented)
      else $error("ram location not implemented");

   // register area at the top holds only the bank pointer here
   sfr_region_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.op != dbm_pkg::DBM_OP_NONE && is_sfr && !is_bptr)
      |=> !rsp.implemented && rsp.rdata == 8'h00)
      else $error("register area read not zero");

   // a read of the last written ram byte returns that byte
   ram_data_a: assert property (@(posedge clk) disable iff (!rst_n)
      (req.op != dbm_pkg::DBM_OP_NONE && !req.wr && shadow_vld_q && addr_c == shadow_addr_q)
      |=> rsp.rdata == $past(shadow_data_q))
      else $error("ram byte lost");

   // ***************************************************
   // covers
   // ***************************************************
   access_cov: cover property (@(posedge clk) disable iff (!rst_n)
      req.op == dbm_pkg::DBM_OP_BANKED && !req.access_sel);
   banked_cov: cover property (@(posedge clk) disable iff (!rst_n)
      req.op == dbm_pkg::DBM_OP_BANKED && req.access_sel);
   full_cov: cover property (@(posedge clk) disable iff (!rst_n)
      req.op == dbm_pkg::DBM_OP_FULL && req.wr);
   unimpl_cov: cover property (@(posedge clk) disable iff (!rst_n)
      rsp.valid && !rsp.implemented);
   bank_wr_cov: cover property (@(posedge clk) disable iff (!rst_n)
      req.op != dbm_pkg::DBM_OP_NONE && req.wr && is_bptr);
endmodule // dbm_mapper

`default_nettype wire

// ---- test/dbm_decoder_model.sv ----
// decoder-side model that issues one mapper request per call
// assumes the caller sits on a falling edge of clk when it calls send
`default_nettype none

module dbm_decoder_model (
   // clock
   input wire logic clk,
   // request toward the mapper
   output var dbm_pkg::dbm_req_t req
);
   timeunit 1ns;
   timeprecision 1ps;

   // idle request at time zero
   initial req = '0;

   // ***************************************************
   // request issue
   // ***************************************************
   // hold the request across one rising edge, then go idle with inverted fields
   // so the mapper cannot lean on stale values
   task automatic send(input dbm_pkg::dbm_op_t op, input logic sel, input logic [7:0] file,
                       input logic [11:0] full, input logic wr, input logic [7:0] wd);
      req = '{op: op, access_sel: sel, file: file, full: full, wr: wr, wdata: wd};
      @(posedge clk);
      @(negedge clk);
      req = '{op: dbm_pkg::DBM_OP_NONE, access_sel: ~sel, file: ~file, full: ~full, wr: ~wr, wdata: ~wd};
   endtask
endmodule // dbm_decoder_model

`default_nettype wire

// ---- test/data_memory_bank_mapper_tb.sv ----
// self-checking bench for the data memory bank mapper
// assumes the mapper answers one cycle after the request edge
`default_nettype none

module data_memory_bank_mapper_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ***************************************************
   // signals
   // ***************************************************
   logic clk = 1'b0;          // 50 MHz core clock
   logic arst_n = 1'b0;       // reset held from time zero
   logic ext_isa = 1'b0;      // extended isa configuration
   dbm_pkg::dbm_req_t req;    // from decoder model
   dbm_pkg::dbm_rsp_t rsp;    // mapper answer
   logic [7:0] bank_ptr;      // bank pointer view
   int fail_count = 0;        // mismatches
   int checked = 0;           // comparisons made
   logic [7:0] offs [4] = '{8'h00, 8'h5F, 8'h60, 8'hFF}; // window edges
   logic [11:0] ea;           // expected address

   always #10 clk = ~clk;

   dbm_decoder_model DEC (.clk(clk), .req(req));
   dbm_mapper DUT (.clk(clk), .arst_n(arst_n), .extended_isa_enable(ext_isa), .req(req), .rsp(rsp),
                   .bank_pointer_o(bank_ptr));

   // ***************************************************
   // helpers
   // ***************************************************
   task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one access; read data and implemented are only compared on reads, though a write answer still carries both
   task automatic acc(input dbm_pkg::dbm_op_t op, input logic sel, input logic [11:0] a, input logic wr,
                      input logic [7:0] wd, input logic [11:0] exp_a, input logic [7:0] ed, input logic ei);
      DEC.send(op, sel, a[7:0], a, wr, wd);
      cmp({11'h000, rsp.valid}, 12'h001);
      cmp(rsp.addr, exp_a);
      if (!wr) begin
         cmp({4'h0, rsp.rdata}, {4'h0, ed});
         cmp({11'h000, rsp.implemented}, {11'h000, ei});
      end
      @(negedge clk);
   endtask

   // reset for 8 cycles, then let the two-flop release settle
   task automatic rst();
      arst_n = 1'b0;
      repeat (8) @(negedge clk);
      arst_n = 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // hang guard
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      end_sim();
   end

   // ***************************************************
   // scenarios
   // ***************************************************
   initial begin
      rst();
      cmp({4'h0, bank_ptr}, 12'h000);
      acc(dbm_pkg::DBM_OP_FULL, 1'b0, 12'hFE0, 1'b0, 8'h00, 12'hFE0, 8'h00, 1'b1);
      acc(dbm_pkg::DBM_OP_FULL, 1'b0, 12'hFE0, 1'b1, 8'hA7, 12'hFE0, 8'h00, 1'b0);
      cmp({4'h0, bank_ptr}, 12'h007);
      acc(dbm_pkg::DBM_OP_BANKED, 1'b0, 12'h0E0, 1'b0, 8'h00, 12'hFE0, 8'h07, 1'b1);
      // window edges with a nonzero bank pointer, which must be ignored
      foreach (offs[i]) begin
         ea = {(offs[i] < 8'h60) ? 4'h0 : 4'hF, offs[i]};
         acc(dbm_pkg::DBM_OP_BANKED, 1'b0, {4'h0, offs[i]}, 1'b1, offs[i] ^ 8'h3C, ea, 8'h00, 1'b0);
         acc(dbm_pkg::DBM_OP_BANKED, 1'b0, {4'h0, offs[i]}, 1'b0, 8'h00, ea,
             (offs[i] < 8'h60) ? offs[i] ^ 8'h3C : 8'h00, offs[i] < 8'h60);
      end
      acc(dbm_pkg::DBM_OP_FULL, 1'b0, 12'hFE0, 1'b1, 8'hF1, 12'hFE0, 8'h00, 1'b0);
      cmp({4'h0, bank_ptr}, 12'h001);
      acc(dbm_pkg::DBM_OP_BANKED, 1'b1, 12'h023, 1'b1, 8'hC3, 12'h123, 8'h00, 1'b0);
      acc(dbm_pkg::DBM_OP_FULL, 1'b0, 12'h123, 1'b0, 8'h00, 12'h123, 8'hC3, 1'b1);
      // unimplemented bank drops writes and reads zero; the ram byte that
      // shares its low address bits must not be touched by the dropped write
      acc(dbm_pkg::DBM_OP_FULL, 1'b0, 12'h144, 1'b1, 8'h5A, 12'h144, 8'h00, 1'b0);
      acc(dbm_pkg::DBM_OP_FULL, 1'b0, 12'hFE0, 1'b1, 8'h05, 12'hFE0, 8'h00, 1'b0);
      acc(dbm_pkg::DBM_OP_BANKED, 1'b1, 12'h044, 1'b1, 8'h99, 12'h544, 8'h00, 1'b0);
      acc(dbm_pkg::DBM_OP_BANKED, 1'b1, 12'h044, 1'b0, 8'h00, 12'h544, 8'h00, 1'b0);
      acc(dbm_pkg::DBM_OP_FULL, 1'b0, 12'h144, 1'b0, 8'h00, 12'h144, 8'h5A, 1'b1);
      // extended isa set: default map still applies here
      ext_isa = 1'b1;
      acc(dbm_pkg::DBM_OP_BANKED, 1'b0, 12'h065, 1'b0, 8'h00, 12'hF65, 8'h00, 1'b0);
      ext_isa = 1'b0;
      // ram survives a second reset, bank pointer does not
      rst();
      cmp({4'h0, bank_ptr}, 12'h000);
      acc(dbm_pkg::DBM_OP_FULL, 1'b0, 12'h000, 1'b0, 8'h00, 12'h000, 8'h3C, 1'b1);
      acc(dbm_pkg::DBM_OP_FULL, 1'b0, 12'h123, 1'b0, 8'h00, 12'h123, 8'hC3, 1'b1);
      end_sim();
   end
endmodule // data_memory_bank_mapper_tb

`default_nettype wire
